// [sml_host.sv]
// host controller model driving the three-wire serial link
// assumes clock is the 125 MHz system clock; pins change just after its rising edge
`timescale 1ns/100ps
module sml_host (
    input wire logic clock,
    output logic serial_clock,
    output logic serial_data,
    output logic mod_in,
    output logic load_b
);
    // ********************************************************
    // idle levels
    // ********************************************************
    initial begin
        serial_clock = 1'b0;
        serial_data = 1'b0;
        mod_in = 1'b1;
        load_b = 1'b1;
    end

    task automatic hold(input int n);
        repeat (n) @(posedge clock);
    endtask

    // ********************************************************
    // frame driver
    // ********************************************************
    // strobe spans n rising serial_clock edges
    task automatic send(input int n, input logic [15:0] bits, input logic alt);
        logic b;
        @(posedge clock);
        load_b <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            b = bits[i];
            serial_data <= alt ? ~b : b;
            mod_in <= alt ? b : ~b;
            hold(4);
            serial_clock <= 1'b1;
            hold(4);
            serial_clock <= 1'b0;
            hold(1);
        end
        hold(3);
        load_b <= 1'b1;
        serial_data <= ~serial_data;
        mod_in <= ~mod_in;
        hold(8);
    endtask

    task automatic stray(input int n);
        repeat (n) begin
            @(posedge clock);
            serial_clock <= 1'b1;
            hold(4);
            serial_clock <= 1'b0;
            hold(3);
        end
    endtask
endmodule

// [sml_loader.sv]
// serial modulation loader: three-wire link, modulation unit, output mux
// assumes all pin inputs are asynchronous to clock and slow against 125 MHz
`timescale 1ns/100ps
module sml_loader (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic mod_in,
    input wire logic load_b,
    input wire logic main_compare_clock,
    input wire logic aux_compare_clock,
    input wire logic ref_osc,
    input wire logic main_ref,
    input wire logic aux_ref,
    output logic signed [sml_pkg::OFFSET_W-1:0] mod_offset_reg,
    output logic mod_update_reg,
    output logic frame_reject_reg,
    output logic mux_out_reg,
    output logic mux_oe_reg
);

    // ********************************************************
    // pin synchronisers
    // ********************************************************
    logic [sml_pkg::PIN_N-1:0] pin_meta_reg;
    logic [sml_pkg::PIN_N-1:0] pin_sync_reg;
    logic sclk_prev_reg;
    logic cmp_prev_reg;
    wire [sml_pkg::PIN_N-1:0] pin_raw = {aux_ref, main_ref, ref_osc, aux_compare_clock,
                                         main_compare_clock, load_b, mod_in, serial_data, serial_clock};

    always_ff @(posedge clock) begin
        pin_meta_reg <= pin_raw;
        pin_sync_reg <= pin_meta_reg;
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sclk_prev_reg <= 1'b0;
            cmp_prev_reg <= 1'b0;
        end else begin
            sclk_prev_reg <= pin_sync_reg[sml_pkg::PIN_SCLK];
            cmp_prev_reg <= pin_sync_reg[sml_pkg::PIN_MAIN_CMP];
        end
    end

    wire sclk_rise = pin_sync_reg[sml_pkg::PIN_SCLK] & ~sclk_prev_reg;
    wire cmp_fall = ~pin_sync_reg[sml_pkg::PIN_MAIN_CMP] & cmp_prev_reg;
    wire load_low = ~pin_sync_reg[sml_pkg::PIN_LOADB];

    // ********************************************************
    // link state and shifting
    // ********************************************************
    sml_pkg::sml_link_t state_reg;
    sml_pkg::sml_link_t state_next;
    logic [sml_pkg::FRAME_W-1:0] main_shreg_reg;
    logic [sml_pkg::FRAME_W-1:0] alt_shreg_reg;
    logic [sml_pkg::CNT_W-1:0] count_reg;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            sml_pkg::SML_LK_IDLE: begin
                if (load_low) begin
                    state_next = sml_pkg::SML_LK_SHIFT;
                end
            end
            sml_pkg::SML_LK_SHIFT: begin
                if (!load_low) begin
                    state_next = sml_pkg::SML_LK_LOAD;
                end
            end
            sml_pkg::SML_LK_LOAD: begin
                state_next = sml_pkg::SML_LK_IDLE;
            end
            default: begin
                state_next = sml_pkg::SML_LK_IDLE;
            end
        endcase
    end

    wire shift_en = load_low & sclk_rise & (state_reg != sml_pkg::SML_LK_LOAD);

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_reg <= sml_pkg::SML_LK_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            main_shreg_reg <= '0;
            alt_shreg_reg <= '0;
        end else if (shift_en) begin
            main_shreg_reg <= {main_shreg_reg[sml_pkg::FRAME_W-2:0], pin_sync_reg[sml_pkg::PIN_SDATA]};
            alt_shreg_reg <= {alt_shreg_reg[sml_pkg::FRAME_W-2:0], pin_sync_reg[sml_pkg::PIN_MODIN]};
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b || state_reg == sml_pkg::SML_LK_LOAD) begin
            count_reg <= '0;
        end else if (shift_en && count_reg != sml_pkg::CNT_SAT) begin
            count_reg <= count_reg + 5'h01;
        end
    end

    // ********************************************************
    // frame decode
    // ********************************************************
    sml_pkg::sml_ctrl_t ctrl_reg;
    sml_pkg::sml_gen_t gen_reg;
    logic signed [sml_pkg::SAMPLE_W-1:0] sample_reg;
    logic signed [sml_pkg::SAMPLE_W-1:0] unit_reg;

    wire committing = state_reg == sml_pkg::SML_LK_LOAD;
    wire frame_full = count_reg == sml_pkg::FRAME_BITS;
    wire free_ok = count_reg >= sml_pkg::FREE_MIN_BITS && count_reg <= sml_pkg::FREE_MAX_BITS;
    wire free_mode = ctrl_reg.addr_disable;
    wire [sml_pkg::ADDR_W-1:0] main_addr = main_shreg_reg[sml_pkg::FRAME_W-1:sml_pkg::SAMPLE_W];
    wire [sml_pkg::ADDR_W-1:0] alt_addr = alt_shreg_reg[sml_pkg::FRAME_W-1:sml_pkg::SAMPLE_W];
    wire [sml_pkg::SAMPLE_W-1:0] main_word = main_shreg_reg[sml_pkg::SAMPLE_W-1:0];
    wire [sml_pkg::SAMPLE_W-1:0] alt_word = alt_shreg_reg[sml_pkg::SAMPLE_W-1:0];

    wire [sml_pkg::SAMPLE_W-1:0] free_src = ctrl_reg.input_select ? alt_word : main_word;
    wire [sml_pkg::CNT_W-1:0] ext_gap = sml_pkg::SAMPLE_W5 - count_reg;
    wire [3:0] ext_shift = ext_gap[3:0];
    wire [sml_pkg::SAMPLE_W-1:0] free_left = free_src << ext_shift;
    wire signed [sml_pkg::SAMPLE_W-1:0] free_ext = $signed(free_left) >>> ext_shift;

    wire load_free = committing & free_mode & free_ok;
    wire load_addr = committing & frame_full;
    wire wr_ctrl = load_addr & (main_addr == sml_pkg::ADDR_MOD_CONTROL);
    wire wr_gen = load_addr & (main_addr == sml_pkg::ADDR_GENERAL);
    wire wr_sample_main = load_addr & ~ctrl_reg.input_select & (main_addr == sml_pkg::ADDR_MOD_SAMPLE);
    wire wr_sample_alt = load_addr & ctrl_reg.input_select & (alt_addr == sml_pkg::ADDR_MOD_SAMPLE);
    wire reject_now = committing & free_mode & ~free_ok & ~frame_full;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ctrl_reg <= '0;
            gen_reg <= '0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= main_word[sml_pkg::CTRL_W-1:0];
            end
            if (wr_gen) begin
                gen_reg.mux_select <= sml_pkg::sml_mux_t'(main_word[sml_pkg::GEN_MUX_MSB:sml_pkg::GEN_MUX_LSB]);
                gen_reg.tristate <= main_word[sml_pkg::GEN_TRI_BIT];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            sample_reg <= '0;
        end else if (load_free) begin
            sample_reg <= free_ext;
        end else if (wr_sample_alt) begin
            sample_reg <= $signed(alt_word);
        end else if (wr_sample_main) begin
            sample_reg <= $signed(main_word);
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            frame_reject_reg <= 1'b0;
        end else begin
            frame_reject_reg <= reject_now;
        end
    end

    // ********************************************************
    // modulation unit
    // ********************************************************
    wire [3:0] mag_eff = (ctrl_reg.magnitude > sml_pkg::MAG_MAX) ? sml_pkg::MAG_MAX : ctrl_reg.magnitude;
    wire signed [sml_pkg::OFFSET_W-1:0] unit_wide = sml_pkg::OFFSET_W'(unit_reg);
    wire signed [sml_pkg::OFFSET_W-1:0] unit_scaled = unit_wide <<< mag_eff;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            unit_reg <= '0;
            mod_offset_reg <= '0;
            mod_update_reg <= 1'b0;
        end else begin
            mod_update_reg <= cmp_fall;
            if (cmp_fall) begin
                unit_reg <= sample_reg;
                mod_offset_reg <= unit_scaled;
            end
        end
    end

    // ********************************************************
    // output multiplexer
    // ********************************************************
    logic mux_sel_w;

    always_comb begin
        unique case (gen_reg.mux_select)
            sml_pkg::SML_MUX_REF_OSC: mux_sel_w = pin_sync_reg[sml_pkg::PIN_REF_OSC];
            sml_pkg::SML_MUX_AUX_REF: mux_sel_w = pin_sync_reg[sml_pkg::PIN_AUX_REF];
            sml_pkg::SML_MUX_MAIN_REF: mux_sel_w = pin_sync_reg[sml_pkg::PIN_MAIN_REF];
            sml_pkg::SML_MUX_AUX_CMP: mux_sel_w = pin_sync_reg[sml_pkg::PIN_AUX_CMP];
            sml_pkg::SML_MUX_MAIN_CMP: mux_sel_w = pin_sync_reg[sml_pkg::PIN_MAIN_CMP];
            sml_pkg::SML_MUX_LOOPBACK: mux_sel_w = pin_sync_reg[sml_pkg::PIN_SDATA];
            sml_pkg::SML_MUX_TEST: mux_sel_w = main_shreg_reg[sml_pkg::FRAME_W-1];
            sml_pkg::SML_MUX_UNUSED: mux_sel_w = 1'b0;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            mux_out_reg <= 1'b0;
            mux_oe_reg <= 1'b0;
        end else begin
            mux_out_reg <= mux_sel_w;
            mux_oe_reg <= ~gen_reg.tristate;
        end
    end

    // ********************************************************
    // assertions
    // ********************************************************
    property p_update_on_fall;
        @(posedge clock) disable iff (!rst_b)
        cmp_fall |=> mod_update_reg && mod_offset_reg == ($past(unit_wide) <<< $past(mag_eff));
    endproperty
    a_update_on_fall: assert property (p_update_on_fall) else $error("offset not updated on fall");

    property p_two_fall_path;
        @(posedge clock) disable iff (!rst_b)
        cmp_fall |=> unit_reg == $past(sample_reg);
    endproperty
    a_two_fall_path: assert property (p_two_fall_path) else $error("sample not moved into unit");

    property p_idle_count;
        @(posedge clock) disable iff (!rst_b)
        state_reg == sml_pkg::SML_LK_IDLE |-> count_reg == 5'h00;
    endproperty
    a_idle_count: assert property (p_idle_count) else $error("edges counted outside strobe");

    property p_free_load;
        @(posedge clock) disable iff (!rst_b)
        load_free |=> sample_reg == $past(free_ext) && !frame_reject_reg;
    endproperty
    a_free_load: assert property (p_free_load) else $error("short sample not loaded");

    property p_reject;
        @(posedge clock) disable iff (!rst_b)
        (committing && free_mode && count_reg > sml_pkg::FREE_MAX_BITS && !frame_full)
        |=> frame_reject_reg && $stable(sample_reg);
    endproperty
    a_reject: assert property (p_reject) else $error("bad width not rejected");

    property p_ctrl_only_full;
        @(posedge clock) disable iff (!rst_b)
        !$stable(ctrl_reg) |-> $past(committing) && $past(count_reg) == sml_pkg::FRAME_BITS;
    endproperty
    a_ctrl_only_full: assert property (p_ctrl_only_full) else $error("control changed off frame");

    property p_alt_source;
        @(posedge clock) disable iff (!rst_b)
        (load_free && ctrl_reg.input_select && count_reg == sml_pkg::FREE_MAX_BITS)
        |=> sample_reg == $signed($past(alt_word));
    endproperty
    a_alt_source: assert property (p_alt_source) else $error("alternate pin not used");

    property p_mux_main_cmp;
        @(posedge clock) disable iff (!rst_b)
        gen_reg.mux_select == sml_pkg::SML_MUX_MAIN_CMP
        |=> mux_out_reg == $past(pin_sync_reg[sml_pkg::PIN_MAIN_CMP]);
    endproperty
    a_mux_main_cmp: assert property (p_mux_main_cmp) else $error("mux route wrong");

    property p_tristate;
        @(posedge clock) disable iff (!rst_b)
        gen_reg.tristate ##1 gen_reg.tristate |-> !mux_oe_reg;
    endproperty
    a_tristate: assert property (p_tristate) else $error("mux pin not tristated");

endmodule

// [sml_loader_tb.sv]
// self-checking bench of the serial modulation loader
// assumes sml_host drives the link pins; the bench drives clocks and mux sources
`timescale 1ns/100ps
module sml_loader_tb;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic main_compare_clock = 1'b0;
    logic aux_compare_clock = 1'b0;
    logic ref_osc = 1'b0;
    logic main_ref = 1'b0;
    logic aux_ref = 1'b0;
    logic serial_clock, serial_data, mod_in, load_b;
    logic signed [24:0] mod_offset_reg;
    logic mod_update_reg, frame_reject_reg, mux_out_reg, mux_oe_reg;
    int err_total = 0;
    int n_checks = 0;
    int n_upd = 0;
    int n_rej = 0;
    int u0;
    logic signed [24:0] keep;
    logic [7:0] src;
    int wid[3] = '{2, 5, 12};
    logic [11:0] pat[3] = '{12'h002, 12'h016, 12'h9a5};
    int mags[3] = '{0, 13, 15};

    always #4 clock = ~clock;

    sml_host host (.clock(clock), .serial_clock(serial_clock), .serial_data(serial_data),
        .mod_in(mod_in), .load_b(load_b));
    sml_loader DUT (.clock(clock), .rst_b(rst_b), .serial_clock(serial_clock),
        .serial_data(serial_data), .mod_in(mod_in), .load_b(load_b),
        .main_compare_clock(main_compare_clock), .aux_compare_clock(aux_compare_clock),
        .ref_osc(ref_osc), .main_ref(main_ref), .aux_ref(aux_ref),
        .mod_offset_reg(mod_offset_reg), .mod_update_reg(mod_update_reg),
        .frame_reject_reg(frame_reject_reg), .mux_out_reg(mux_out_reg), .mux_oe_reg(mux_oe_reg));

    always @(posedge clock) begin
        if (mod_update_reg === 1'b1) n_upd++;
        if (frame_reject_reg === 1'b1) n_rej++;
    end

    // ********************************************************
    // helpers
    // ********************************************************
    task automatic check(input string what, input logic [24:0] seen, input logic [24:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic logic signed [24:0] scaled(input logic [11:0] s, input int n, input int m);
        logic signed [11:0] t;
        logic signed [24:0] v;
        t = s << (12 - n);
        v = t;
        v = v >>> (12 - n);
        return v <<< m;
    endfunction

    task automatic wr(input logic [3:0] addr, input logic [11:0] data);
        host.send(16, {addr, data}, 1'b0);
    endtask

    task automatic fall();
        @(posedge clock);
        main_compare_clock <= 1'b1;
        repeat (5) @(posedge clock);
        main_compare_clock <= 1'b0;
        repeat (6) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial begin
        #400000;
        err_total++;
        summarize();
    end

    // ********************************************************
    // tests
    // ********************************************************
    initial begin
        repeat (4) @(posedge clock);
        @(negedge clock);
        check("offset in reset", mod_offset_reg, 25'h0);
        check("oe in reset", 25'(mux_oe_reg), 25'h0);
        @(posedge clock);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        @(negedge clock);
        check("oe after reset", 25'(mux_oe_reg), 25'h1);
        $display("test reset done");

        wr(sml_pkg::ADDR_MOD_CONTROL, 12'h003);
        wr(sml_pkg::ADDR_MOD_SAMPLE, 12'h800);
        u0 = n_upd;
        fall();
        fall();
        check("offset min", mod_offset_reg, scaled(12'h800, 12, 3));
        check("update pulses", 25'(n_upd - u0), 25'h2);
        host.stray(3);
        wr(sml_pkg::ADDR_MOD_SAMPLE, 12'h7ff);
        fall();
        check("offset one fall", mod_offset_reg, scaled(12'h800, 12, 3));
        fall();
        check("offset max", mod_offset_reg, scaled(12'h7ff, 12, 3));
        $display("test pipeline done");

        for (int i = 0; i < 3; i++) begin
            wr(sml_pkg::ADDR_MOD_CONTROL, 12'(mags[i]));
            wr(sml_pkg::ADDR_MOD_SAMPLE, 12'hfff);
            fall();
            fall();
            check("magnitude", mod_offset_reg, scaled(12'hfff, 12, (mags[i] > 13) ? 13 : mags[i]));
        end
        $display("test magnitude done");

        wr(sml_pkg::ADDR_MOD_CONTROL, 12'h020);
        for (int i = 0; i < 3; i++) begin
            host.send(wid[i], {4'h0, pat[i]}, 1'b0);
            fall();
            fall();
            check("short frame", mod_offset_reg, scaled(pat[i], wid[i], 0));
        end
        keep = mod_offset_reg;
        for (int n = 1; n <= 13; n += 12) begin
            u0 = n_rej;
            host.send(n, 16'h1555, 1'b0);
            fall();
            fall();
            check("reject pulse", 25'(n_rej - u0), 25'h1);
            check("reject keeps", mod_offset_reg, keep);
        end
        $display("test short frames done");

        wr(sml_pkg::ADDR_MOD_CONTROL, 12'h031);
        host.send(6, 16'h001b, 1'b1);
        fall();
        fall();
        check("alternate pin", mod_offset_reg, scaled(12'h01b, 6, 1));
        host.send(12, 16'h0a5c, 1'b1);
        fall();
        fall();
        check("alternate full", mod_offset_reg, scaled(12'ha5c, 12, 1));
        wr(sml_pkg::ADDR_MOD_CONTROL, 12'h012);
        host.send(16, {sml_pkg::ADDR_MOD_SAMPLE, 12'h123}, 1'b1);
        fall();
        fall();
        check("alternate frame", mod_offset_reg, scaled(12'h123, 12, 2));
        wr(sml_pkg::ADDR_MOD_CONTROL, 12'h000);
        $display("test alternate pin done");

        for (int c = 0; c < 8; c++) begin
            wr(sml_pkg::ADDR_GENERAL, 12'(c) << 6);
            for (int p = 0; p < 2; p++) begin
                @(posedge clock);
                {ref_osc, aux_ref, main_ref, aux_compare_clock, main_compare_clock} <= p ? 5'h15 : 5'h0a;
                repeat (6) @(posedge clock);
                @(negedge clock);
                src = {1'b0, 1'b0, serial_data, main_compare_clock, aux_compare_clock,
                    main_ref, aux_ref, ref_osc};
                check("mux out", 25'(mux_out_reg), 25'(src[c]));
            end
        end
        wr(sml_pkg::ADDR_GENERAL, 12'h200);
        @(negedge clock);
        check("oe off", 25'(mux_oe_reg), 25'h0);
        wr(sml_pkg::ADDR_GENERAL, 12'h000);
        @(negedge clock);
        check("oe on", 25'(mux_oe_reg), 25'h1);
        $display("test mux done");
        summarize();
    end
endmodule

// [sml_pkg.sv]
// constants, field layouts and types of the serial modulation loader
// assumes a single 125 MHz clock domain; all pins arrive asynchronously
package sml_pkg;

    // ********************************************************
    // serial frame layout
    // ********************************************************
    localparam int ADDR_W = 4;
    localparam int SAMPLE_W = 12;
    localparam int FRAME_W = ADDR_W + SAMPLE_W;
    localparam int CNT_W = 5;
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] FREE_MIN_BITS = 5'h02;
    localparam logic [4:0] FREE_MAX_BITS = 5'h0c;
    localparam logic [4:0] CNT_SAT = 5'h1f;
    localparam logic [4:0] SAMPLE_W5 = 5'h0c;

    // ********************************************************
    // register addresses carried in the frame
    // ********************************************************
    localparam logic [3:0] ADDR_GENERAL = 4'h3;
    localparam logic [3:0] ADDR_MOD_CONTROL = 4'h5;
    localparam logic [3:0] ADDR_MOD_SAMPLE = 4'h6;

    // ********************************************************
    // field positions
    // ********************************************************
    localparam int CTRL_W = 6;
    localparam int GEN_MUX_LSB = 6;
    localparam int GEN_MUX_MSB = 8;
    localparam int GEN_TRI_BIT = 9;
    localparam logic [3:0] MAG_MAX = 4'hd;
    localparam int OFFSET_W = SAMPLE_W + 13;

    // ********************************************************
    // synchroniser lane indices
    // ********************************************************
    localparam int PIN_N = 9;
    localparam int PIN_SCLK = 0;
    localparam int PIN_SDATA = 1;
    localparam int PIN_MODIN = 2;
    localparam int PIN_LOADB = 3;
    localparam int PIN_MAIN_CMP = 4;
    localparam int PIN_AUX_CMP = 5;
    localparam int PIN_REF_OSC = 6;
    localparam int PIN_MAIN_REF = 7;
    localparam int PIN_AUX_REF = 8;

    // ********************************************************
    // types
    // ********************************************************
    typedef enum logic [2:0] {
        SML_MUX_REF_OSC = 3'h0,
        SML_MUX_AUX_REF = 3'h1,
        SML_MUX_MAIN_REF = 3'h2,
        SML_MUX_AUX_CMP = 3'h3,
        SML_MUX_MAIN_CMP = 3'h4,
        SML_MUX_LOOPBACK = 3'h5,
        SML_MUX_TEST = 3'h6,
        SML_MUX_UNUSED = 3'h7
    } sml_mux_t;

    typedef enum logic [1:0] {
        SML_LK_IDLE = 2'h0,
        SML_LK_SHIFT = 2'h1,
        SML_LK_LOAD = 2'h3
    } sml_link_t;

    // modulation control word, msb first as shifted in
    typedef struct packed {
        logic addr_disable;
        logic input_select;
        logic [3:0] magnitude;
    } sml_ctrl_t;

    typedef struct packed {
        sml_mux_t mux_select;
        logic tristate;
    } sml_gen_t;

endpackage
